// ### verilog/cfsc_pkg.sv
// Shared types and constants of the carrierband FSK symbol codec
package cfsc_pkg;

   // MAC symbol codes on the three symbol lines (codes 5 and 6 are sent as silence)
   typedef enum logic [2:0] {
      CFSC_SYM_ZERO    = 3'h0,
      CFSC_SYM_ONE     = 3'h1,
      CFSC_SYM_ND1     = 3'h2,
      CFSC_SYM_ND2     = 3'h3,
      CFSC_SYM_PAD     = 3'h4,
      CFSC_SYM_SILENCE = 3'h7
   } cfsc_sym_t;

   // Half-symbol kinds on the line
   typedef enum logic [1:0] {
      CFSC_HS_OFF  = 2'h0,
      CFSC_HS_LOW  = 2'h1,
      CFSC_HS_HIGH = 2'h2
   } cfsc_half_t;

   // Management commands, carried on the symbol lines while the request line is high
   typedef enum logic [2:0] {
      CFSC_CMD_NOP      = 3'h0,
      CFSC_CMD_RESET    = 3'h1,
      CFSC_CMD_TX_ON    = 3'h2,
      CFSC_CMD_TX_OFF   = 3'h3,
      CFSC_CMD_LOOP_ON  = 3'h4,
      CFSC_CMD_LOOP_OFF = 3'h5
   } cfsc_cmd_t;

   // Request channel from the controller
   typedef struct packed {
      logic      mgmt;
      logic [2:0] sym;
   } cfsc_req_t;

   // Indication channel toward the controller
   typedef struct packed {
      logic      mgmt;
      logic [2:0] sym;
   } cfsc_ind_t;

   // Status word positions returned in management mode
   localparam int unsigned ST_TX_EN = 0;
   localparam int unsigned ST_LOOP  = 1;
   localparam int unsigned ST_JAB   = 2;

   // Reset values
   localparam logic TX_EN_RST = 1'b0;
   localparam logic LOOP_RST  = 1'b0;

   // Timing
   localparam int unsigned CLK_NS     = 32'h0000_000A;
   localparam int unsigned JABBER_NS  = 32'h0007_A120;
   localparam int unsigned JABBER_CYC = JABBER_NS / CLK_NS;
   localparam int unsigned BLANK_SYMS = 32'h0000_0004;

endpackage

// ### verilog/cfsc_top.sv
// Carrierband FSK symbol codec: tone modulator, demodulator and link management
//
// What this block does
// - Lower tone: half carrier cycle per half-symbol
// - Successive lower tones alternate polarity
// - Higher tone: one full cycle per half-symbol
// - Silence: no carrier for half a bit
// - 5 Mbps: lower 5 MHz, higher 10 MHz
// - 10 Mbps: lower 10 MHz, higher 20 MHz
// - Tone changes only at zero crossings
// - Each MAC symbol is two half-symbols
// - Fixed half-symbol pairs per MAC symbol, pad-idle LL,HH
// - Receiver ignores absolute line polarity
// - Request channel: three symbols, clock, management
// - Indication channel: three symbols, clock, management
// - Management shares the data mode channels
// - Data mode encodes and transmits controller symbols
// - Data mode demodulates and delivers received symbols
// - Management: reset, transmitter control, loopback
// - Jabber timeout forces transmitter off, reports error
// - Receiver blanked after end of transmission
module cfsc_top #(
   parameter int unsigned JABBER_CYCLES = cfsc_pkg::JABBER_CYC,
   parameter int unsigned BLANK_SYMS    = cfsc_pkg::BLANK_SYMS
) (
   // System clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Reference clock, four times the data rate
   input  wire logic                ref_clk,
   // Request channel from the controller
   input  wire cfsc_pkg::cfsc_req_t req,
   output logic                     txclk,
   // Indication channel toward the controller
   output cfsc_pkg::cfsc_ind_t      ind,
   output logic                     rxclk,
   // Line side
   input  wire logic                line_rx,
   input  wire logic                carrier_det,
   output logic                     line_tx,
   output logic                     line_tx_en
);

   localparam int JW = $clog2(JABBER_CYCLES + 1);
   localparam int BW = $clog2(BLANK_SYMS + 1);

   if (JABBER_CYCLES < 2 || BLANK_SYMS < 1) begin : g_bad_param
      $error("cfsc_top: JABBER_CYCLES must be >= 2 and BLANK_SYMS >= 1");
   end

   // Half-symbol pair for a MAC symbol; pad_hi picks the second pad-idle pair
   function automatic logic [3:0] tx_pair(input logic [2:0] s, input logic pad_hi);
      logic [3:0] p;
      p = {cfsc_pkg::CFSC_HS_OFF, cfsc_pkg::CFSC_HS_OFF};
      unique case (s)
         cfsc_pkg::CFSC_SYM_ZERO: p = {cfsc_pkg::CFSC_HS_HIGH, cfsc_pkg::CFSC_HS_HIGH};
         cfsc_pkg::CFSC_SYM_ONE:  p = {cfsc_pkg::CFSC_HS_LOW, cfsc_pkg::CFSC_HS_LOW};
         cfsc_pkg::CFSC_SYM_ND1:  p = {cfsc_pkg::CFSC_HS_HIGH, cfsc_pkg::CFSC_HS_LOW};
         cfsc_pkg::CFSC_SYM_ND2:  p = {cfsc_pkg::CFSC_HS_LOW, cfsc_pkg::CFSC_HS_HIGH};
         cfsc_pkg::CFSC_SYM_PAD:  p = pad_hi ?
                                      {cfsc_pkg::CFSC_HS_HIGH, cfsc_pkg::CFSC_HS_HIGH} :
                                      {cfsc_pkg::CFSC_HS_LOW, cfsc_pkg::CFSC_HS_LOW};
         default:                 p = {cfsc_pkg::CFSC_HS_OFF, cfsc_pkg::CFSC_HS_OFF};
      endcase
      return p;
   endfunction

   // MAC symbol for a received half-symbol pair
   function automatic logic [2:0] rx_pair(input logic [1:0] a, input logic [1:0] b);
      logic [2:0] s;
      s = cfsc_pkg::CFSC_SYM_SILENCE;
      if (a == cfsc_pkg::CFSC_HS_HIGH && b == cfsc_pkg::CFSC_HS_HIGH) begin
         s = cfsc_pkg::CFSC_SYM_ZERO;
      end else if (a == cfsc_pkg::CFSC_HS_LOW && b == cfsc_pkg::CFSC_HS_LOW) begin
         s = cfsc_pkg::CFSC_SYM_ONE;
      end else if (a == cfsc_pkg::CFSC_HS_HIGH && b == cfsc_pkg::CFSC_HS_LOW) begin
         s = cfsc_pkg::CFSC_SYM_ND1;
      end else if (a == cfsc_pkg::CFSC_HS_LOW && b == cfsc_pkg::CFSC_HS_HIGH) begin
         s = cfsc_pkg::CFSC_SYM_ND2;
      end
      return s;
   endfunction

   // ---------------- Reference clock domain ----------------

   logic [1:0]          rrst_sync;
   logic                rrst_n;
   cfsc_pkg::cfsc_req_t req_m;
   cfsc_pkg::cfsc_req_t req_s;
   logic [1:0]          rxin_m;
   logic [1:0]          rxin_s;
   logic                jab_m;
   logic                jab_s;
   logic [1:0]          phase;
   logic [2:0]          cur_sym;
   logic                pad_hi;
   logic                pol;
   logic                tx_en;
   logic                loop;
   logic                rst_tgl;
   logic                samp;
   logic [1:0]          rx_first;
   logic [2:0]          rx_last;
   logic [BW-1:0]       blank_cnt;
   logic [2:0]          rx_word;
   // Jabber flag lives in the clk domain; declared here as the ref side reads it
   logic                jab_err;

   // Reset release into the reference domain
   always_ff @(posedge ref_clk) begin
      rrst_sync <= {rrst_sync[0], rst_n};
   end
   assign rrst_n = rrst_sync[1];

   // Pin inputs: two stages before use
   always_ff @(posedge ref_clk) begin
      req_m  <= req;
      req_s  <= req_m;
      rxin_m <= {carrier_det, line_rx};
      rxin_s <= rxin_m;
      jab_m  <= jab_err;
      jab_s  <= jab_m;
   end

   // Symbol timing: four reference ticks per bit, two per half-symbol
   wire [1:0] next_phase = phase + 2'h1;
   wire       sym_edge   = (phase == 2'h3);
   wire       next_clk   = ~next_phase[1];

   always_ff @(posedge ref_clk) begin
      if (!rrst_n) begin
         // Start on the last tick so the first edge out of reset opens a full bit
         phase <= 2'h3;
         txclk <= 1'b0;
         rxclk <= 1'b0;
      end else begin
         phase <= next_phase;
         txclk <= next_clk;
         rxclk <= next_clk;
      end
   end

   // Management command decode
   wire                      cmd_take = sym_edge & req_s.mgmt;
   wire cfsc_pkg::cfsc_cmd_t cmd      = cfsc_pkg::cfsc_cmd_t'(req_s.sym);

   always_ff @(posedge ref_clk) begin
      if (!rrst_n) begin
         tx_en   <= cfsc_pkg::TX_EN_RST;
         loop    <= cfsc_pkg::LOOP_RST;
         rst_tgl <= 1'b0;
      end else if (cmd_take) begin
         unique case (cmd)
            cfsc_pkg::CFSC_CMD_RESET: begin
               tx_en   <= cfsc_pkg::TX_EN_RST;
               loop    <= cfsc_pkg::LOOP_RST;
               rst_tgl <= ~rst_tgl;
            end
            cfsc_pkg::CFSC_CMD_TX_ON:    tx_en <= 1'b1;
            cfsc_pkg::CFSC_CMD_TX_OFF:   tx_en <= 1'b0;
            cfsc_pkg::CFSC_CMD_LOOP_ON:  loop  <= 1'b1;
            cfsc_pkg::CFSC_CMD_LOOP_OFF: loop  <= 1'b0;
            default: ;
         endcase
      end
   end

   // Transmit path: symbol taken at end of each bit, played over the next
   wire [2:0] next_sym = req_s.mgmt ? cfsc_pkg::CFSC_SYM_SILENCE : req_s.sym;
   wire [3:0] pair     = tx_pair(cur_sym, pad_hi);
   wire [1:0] cur_half = phase[1] ? pair[1:0] : pair[3:2];
   wire       is_high  = (cur_half == cfsc_pkg::CFSC_HS_HIGH);
   wire       is_low   = (cur_half == cfsc_pkg::CFSC_HS_LOW);
   // Jabber trip and disable both gate the line driver
   wire       tx_gate  = tx_en & ~jab_s & ~loop;
   wire       drive    = (is_high | is_low) & (tx_gate | loop);
   // High: level flips mid half-symbol; low: level held whole half-symbol
   wire       next_line = is_high ? (pol ^ phase[0]) : pol;
   // The driver enable, not the carrier level, says the transmitter is on
   wire       line_now  = line_tx_en;

   always_ff @(posedge ref_clk) begin
      if (!rrst_n) begin
         cur_sym    <= cfsc_pkg::CFSC_SYM_SILENCE;
         pad_hi     <= 1'b0;
         pol        <= 1'b0;
         line_tx    <= 1'b0;
         line_tx_en <= 1'b0;
      end else begin
         if (sym_edge) begin
            cur_sym <= next_sym;
            // A pad run always opens with the lower pair
            if (next_sym == cfsc_pkg::CFSC_SYM_PAD && cur_sym == cfsc_pkg::CFSC_SYM_PAD) begin
               pad_hi <= ~pad_hi;
            end else begin
               pad_hi <= 1'b0;
            end
         end
         // Polarity only moves at half-symbol boundaries, so every change is at zero
         if (is_low && phase[0]) begin
            pol <= ~pol;
         end
         line_tx    <= next_line;
         line_tx_en <= drive & tx_gate;
      end
   end

   // Loopback keeps the line quiet and feeds the modulator back to the receiver
   // Three stages, like driver register plus pin synchroniser, so both paths line up
   logic [2:0] lb_line;
   logic [2:0] lb_on;
   always_ff @(posedge ref_clk) begin
      if (!rrst_n) begin
         lb_line <= 3'h0;
         lb_on   <= 3'h0;
      end else begin
         lb_line <= {lb_line[1:0], next_line};
         lb_on   <= {lb_on[1:0], drive & loop};
      end
   end

   wire rx_lvl = loop ? lb_line[2] : rxin_s[0];
   wire rx_cd  = loop ? lb_on[2] : rxin_s[1];
   // Own halves come back three ticks late: tick 0 seen in phase 3, tick 3 in phase 2
   wire rx_mid  = (phase == 2'h0);
   wire rx_done = (phase == 2'h2);

   // Half-symbol class from a change inside it, not from its sign
   wire [1:0] rx_half = !rx_cd ? cfsc_pkg::CFSC_HS_OFF :
                        (rx_lvl != samp) ? cfsc_pkg::CFSC_HS_HIGH :
                                           cfsc_pkg::CFSC_HS_LOW;
   wire [2:0] rx_dec    = rx_pair(rx_first, rx_half);
   wire       rx_end    = (rx_dec == cfsc_pkg::CFSC_SYM_SILENCE) &&
                          (rx_last != cfsc_pkg::CFSC_SYM_SILENCE);
   wire       blanking  = rx_end || (blank_cnt != '0);
   wire [2:0] rx_report = blanking ? cfsc_pkg::CFSC_SYM_SILENCE : rx_dec;
   wire [2:0] status    = {jab_s, loop, tx_en};

   always_ff @(posedge ref_clk) begin
      if (!rrst_n) begin
         samp      <= 1'b0;
         rx_first  <= cfsc_pkg::CFSC_HS_OFF;
         rx_last   <= cfsc_pkg::CFSC_SYM_SILENCE;
         blank_cnt <= '0;
         rx_word   <= cfsc_pkg::CFSC_SYM_SILENCE;
         ind       <= '{mgmt: 1'b0, sym: cfsc_pkg::CFSC_SYM_SILENCE};
      end else begin
         // First tick of each half is kept for the change test on the second
         if (phase[0]) begin
            samp <= rx_lvl;
         end
         if (rx_mid) begin
            rx_first <= rx_half;
         end
         if (rx_done) begin
            rx_last <= rx_dec;
            rx_word <= rx_report;
            // Trailing line activity after an end is held off for a while
            if (rx_end) begin
               blank_cnt <= BW'(BLANK_SYMS);
            end else if (blank_cnt != '0) begin
               blank_cnt <= blank_cnt - BW'(1);
            end
         end
         // Decoded word waits one tick for the bit boundary the controller sees
         if (sym_edge) begin
            ind.mgmt <= req_s.mgmt;
            ind.sym  <= req_s.mgmt ? status : rx_word;
         end
      end
   end

   // ---------------- System clock domain: jabber timer ----------------

   logic          ton_m;
   logic          ton_s;
   logic          tg_m;
   logic          tg_s;
   logic          tg_d;
   logic [JW-1:0] jab_cnt;

   always_ff @(posedge clk) begin
      ton_m <= line_now;
      ton_s <= ton_m;
      tg_m  <= rst_tgl;
      tg_s  <= tg_m;
      tg_d  <= tg_s;
   end

   wire clr_pulse = tg_s ^ tg_d;
   wire trip      = ton_s && (jab_cnt == JW'(JABBER_CYCLES - 1));

   // Trip wins over a reset command arriving in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         jab_cnt <= '0;
         jab_err <= 1'b0;
      end else begin
         if (!ton_s || clr_pulse) begin
            jab_cnt <= '0;
         end else if (jab_cnt != JW'(JABBER_CYCLES)) begin
            jab_cnt <= jab_cnt + JW'(1);
         end
         jab_err <= trip | (jab_err & ~clr_pulse);
      end
   end

endmodule // cfsc_top

// ### verif/cfsc_monitor.sv
// Port assertions for the FSK symbol codec
module cfsc_monitor #(
   parameter int unsigned JABBER_CYCLES = 50000
) (
   // Clocks and reset
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                ref_clk,
   // Controller side
   input wire cfsc_pkg::cfsc_req_t req,
   input wire logic                txclk,
   input wire cfsc_pkg::cfsc_ind_t ind,
   input wire logic                rxclk,
   // Line side
   input wire logic                line_tx,
   input wire logic                line_tx_en
);
   timeunit 1ns;
   timeprecision 100ps;
   // Slack covers the sync into clk plus the ref ticks to the driver
   logic [31:0] on_cnt;
   always_ff @(posedge clk) begin
      if (!rst_n || !line_tx_en) begin
         on_cnt <= '0;
      end else begin
         on_cnt <= on_cnt + 32'h0000_0001;
      end
   end
   txclk_twin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      txclk == rxclk) else $error("rxclk differs from txclk");
   txclk_shape_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(txclk) |-> ##1 txclk ##1 !txclk ##1 !txclk ##1 $rose(txclk))
      else $error("txclk not two ticks high and two low");
   ind_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !$rose(rxclk) |-> $stable(ind)) else $error("ind moved between rxclk rises");
   carrier_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (line_tx_en && $past(line_tx_en) && $stable(line_tx)) ##1 (line_tx_en && $stable(line_tx))
      |=> (!line_tx_en || $changed(line_tx))) else $error("carrier flat for three ticks");
   mgmt_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req.mgmt[*8] ##1 req.mgmt[*4] |-> !line_tx_en) else $error("line driven in mgmt");
   mgmt_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(ind.mgmt) |-> $past(req.mgmt, 4)) else $error("mgmt flag without request");
   reset_quiet_a: assert property (@(posedge ref_clk)
      !rst_n[*5] |-> !txclk && !rxclk && !line_tx_en && ind == 4'h7)
      else $error("outputs active in reset");
   jabber_cut_a: assert property (@(posedge clk) disable iff (!rst_n)
      on_cnt <= JABBER_CYCLES + 40) else $error("driver kept on past timeout");
endmodule // cfsc_monitor

bind cfsc_top cfsc_monitor #(.JABBER_CYCLES(JABBER_CYCLES)) u_mon (
   .clk(clk), .rst_n(rst_n), .ref_clk(ref_clk), .req(req), .txclk(txclk), .ind(ind),
   .rxclk(rxclk), .line_tx(line_tx), .line_tx_en(line_tx_en));

// ### verif/cfsc_far_model.sv
// Controller and cable stand-in facing the codec
module cfsc_far_model (
   // Bench controls
   input  wire logic           mgmt_in,
   input  wire logic [2:0]     code_in,
   input  wire logic           invert,
   // Controller side
   input  wire logic           txclk,
   output cfsc_pkg::cfsc_req_t req,
   // Cable side
   input  wire logic           line_tx,
   input  wire logic           line_tx_en,
   output logic                line_rx,
   output logic                carrier_det
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] req_q = 4'h7;
   logic       idle_pat = 1'b0;
   // Launched on the codec's clock rise, held a whole bit
   always @(posedge txclk) req_q <= {mgmt_in, code_in};
   // Idle line wanders so a stale level never reads as signal
   always @(posedge txclk) idle_pat <= ~idle_pat;
   assign req = req_q;
   assign line_rx = line_tx_en ? (line_tx ^ invert) : idle_pat;
   assign carrier_det = line_tx_en;
endmodule // cfsc_far_model

// ### verif/tb.sv
// Self-checking bench for the FSK symbol codec
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned JAB = 1000;
   localparam logic [2:0] CODES [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5};
   localparam int         TOGS  [7] = '{32, 16, 24, 24, 24, -1, -1};
   logic                clk = 1'b0;
   logic                ref_clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                mgmt_in = 1'b0;
   logic [2:0]          code_in = 3'h7;
   logic                invert = 1'b0;
   cfsc_pkg::cfsc_req_t req;
   cfsc_pkg::cfsc_ind_t ind;
   logic                txclk, rxclk, line_tx, line_tx_en, line_rx, carrier_det, prev_tx;
   int                  fail_count = 0;
   int                  n_compared = 0;
   int                  tx_rises = 0;
   int                  meas_n = 0;
   int                  toggles, en_ticks;
   always #5 clk = ~clk;
   // Reference at four times the bit rate, off-grid so edges never meet clk
   initial begin
      #1.5;
      forever #24 ref_clk = ~ref_clk;
   end
   always @(posedge txclk) tx_rises++;
   always @(negedge ref_clk) begin
      if (meas_n > 0) begin
         meas_n--;
         if (line_tx !== prev_tx) toggles++;
         if (line_tx_en === 1'b1) en_ticks++;
      end
      prev_tx = line_tx;
   end
   cfsc_top #(.JABBER_CYCLES(JAB)) uut (.clk(clk), .rst_n(rst_n), .ref_clk(ref_clk), .req(req),
      .txclk(txclk), .ind(ind), .rxclk(rxclk), .line_rx(line_rx), .carrier_det(carrier_det),
      .line_tx(line_tx), .line_tx_en(line_tx_en));
   cfsc_far_model far (.mgmt_in(mgmt_in), .code_in(code_in), .invert(invert), .txclk(txclk),
      .req(req), .line_tx(line_tx), .line_tx_en(line_tx_en), .line_rx(line_rx),
      .carrier_det(carrier_det));
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_bits(int n);
      int target;
      target = tx_rises + n;
      for (int k = 0; k < n * 40 && tx_rises < target; k++) @(negedge clk);
      if (tx_rises < target) begin
         check("txclk running", 0, 1);
         conclude();
      end
   endtask
   task automatic send(logic m, logic [2:0] c);
      @(negedge clk);
      mgmt_in = m;
      code_in = c;
   endtask
   task automatic command(logic [2:0] c, logic [2:0] status);
      send(1'b1, c);
      wait_bits(5);
      check("mgmt flag", ind.mgmt, 1'b1);
      check("status", ind.sym, status);
      send(1'b1, 3'h0);
      wait_bits(2);
      $display("command %0d done", c);
   endtask
   // Toggle counts over 32 ticks hold for any start phase of the stream
   task automatic tone(logic [2:0] c, int tog, int en, logic dec, logic inv);
      send(1'b0, c);
      invert = inv;
      wait_bits(4);
      toggles = 0;
      en_ticks = 0;
      meas_n = 32;
      wait_bits(9);
      if (tog >= 0) check("toggles", toggles, tog);
      check("carrier ticks", en_ticks, en);
      if (dec) check("decoded", ind.sym, (c == 3'h5) ? 3'h7 : c);
      send(1'b0, 3'h7);
      wait_bits(4);
      $display("tone %0d done", c);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      @(negedge clk);
      check("txclk in reset", txclk, 1'b0);
      check("driver in reset", line_tx_en, 1'b0);
      check("ind in reset", ind, 4'h7);
      rst_n = 1'b1;
      wait_bits(3);
      check("idle driver", line_tx_en, 1'b0);
      command(cfsc_pkg::CFSC_CMD_NOP, 3'h0);
      command(cfsc_pkg::CFSC_CMD_TX_ON, 3'h1);
      for (int k = 0; k < 7; k++) tone(CODES[k], TOGS[k], (TOGS[k] > 0) ? 32 : 0,
         CODES[k] != 3'h4, k[0]);
      command(cfsc_pkg::CFSC_CMD_TX_OFF, 3'h0);
      command(cfsc_pkg::CFSC_CMD_LOOP_ON, 3'h2);
      tone(cfsc_pkg::CFSC_SYM_ND1, -1, 0, 1'b1, 1'b0);
      command(cfsc_pkg::CFSC_CMD_LOOP_OFF, 3'h0);
      command(cfsc_pkg::CFSC_CMD_TX_ON, 3'h1);
      send(1'b0, cfsc_pkg::CFSC_SYM_ONE);
      wait_bits(70);
      check("driver after timeout", line_tx_en, 1'b0);
      command(cfsc_pkg::CFSC_CMD_NOP, 3'h5);
      command(cfsc_pkg::CFSC_CMD_RESET, 3'h0);
      $display("jabber test done");
      conclude();
   end
endmodule // tb
